// ---- sme_cfg.svh ----
// Constants for the single-master two-wire serial engine.
// Assumes one core clock; every slower rate is derived as an enable pulse.
//
// Overview of operation
// - Transmit ack slot: one clock, store level
// - Data line released during received ack
// - Shift buffer frozen during ack clock
// - Receive ack driven from ack level bit
// - Addressing and free data formats supported
// - Bus clock is source clock divided by three
// - Source: fosc/2,4,16,32, fs/2,4, timer 3
// - Prescaler runs only when mode enables it
// - Direction bit; first byte gets own start
// - Receive releases data line, then sends ack
// - Writing shift buffer sets busy, starts transfer
// - Clearing busy generates stop condition
// - Foreign start during a byte or ack, start generation on: raises done, clears busy
// - Start: data falls while clock high
// - Stop: data rises while clock high
// - Foreign start during a byte or ack, start generation on: sets start-detected flag
// - Received data sampled on clock falling edge
`ifndef SME_CFG_SVH
`define SME_CFG_SVH

// Clock source select codes
`define SME_SRC_FOSC2   3'h0
`define SME_SRC_FOSC4   3'h1
`define SME_SRC_FOSC16  3'h2
`define SME_SRC_FOSC32  3'h3
`define SME_SRC_FS2     3'h4
`define SME_SRC_FS4     3'h5
`define SME_SRC_TMR3    3'h6

// Prescaler masks: tick when all masked counter bits are one
`define SME_PSC_W       5
`define SME_PSC_M2      5'h01
`define SME_PSC_M4      5'h03
`define SME_PSC_M16     5'h0f
`define SME_PSC_M32     5'h1f
`define SME_SUB_M2      2'h1
`define SME_SUB_M4      2'h3

// Bus clock phases: low for two ticks, high for one; the source is divided by three
`define SME_PH_LOW      2'h0
`define SME_PH_HI1      2'h1
`define SME_PH_HI2      2'h2

// Bit counting
`define SME_BIT_FULL    4'h8
`define SME_BIT_ONE     4'h1

`endif

// ---- sme_engine.sv ----
// Single-master two-wire serial engine with its write-data FIFO.
// Assumes open-drain bus pins with external pull-ups; control bits are plain ports.
`timescale 1ns/1ps
`include "sme_cfg.svh"

module sme_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             core_clk_i,
    input  wire logic             reset_n_i,
    // Fill side
    input  wire logic             in_valid_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  in_ready_o,
    // Drain side
    output logic                  out_valid_o,
    output logic [WIDTH-1:0]      out_data_o,
    input  wire logic             out_ready_i
);
    localparam int AW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) $error("sme_fifo: DEPTH must be a power of two");
    end
    logic [WIDTH-1:0] mem_reg [DEPTH];   // Storage words
    logic [AW:0]      wp_reg, wp_next;   // Write pointer, extra wrap bit
    logic [AW:0]      rp_reg, rp_next;   // Read pointer, extra wrap bit
    logic             push, pop;

    // Full when pointers differ only in the wrap bit
    always_comb begin
        in_ready_o  = (wp_reg[AW] == rp_reg[AW]) || (wp_reg[AW-1:0] != rp_reg[AW-1:0]);
        out_valid_o = (wp_reg != rp_reg);
        out_data_o  = mem_reg[rp_reg[AW-1:0]];
        push        = in_valid_i && in_ready_o;
        pop         = out_valid_o && out_ready_i;
        wp_next     = push ? wp_reg + 1'b1 : wp_reg;
        rp_next     = pop ? rp_reg + 1'b1 : rp_reg;
    end

    // Pointer registers
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wp_reg <= '0;
            rp_reg <= '0;
        end else begin
            wp_reg <= wp_next;
            rp_reg <= rp_next;
        end
    end

    // Storage has no reset; only written words are ever read
    always_ff @(posedge core_clk_i) begin
        if (push) begin
            mem_reg[wp_reg[AW-1:0]] <= in_data_i;
        end
    end
endmodule // sme_fifo

module sme_engine
    import sme_pkg::*;
#(
    parameter int FIFO_DEPTH = 8
) (
    // Clock and reset
    input  wire logic       core_clk_i,
    input  wire logic       reset_n_i,
    // Configuration
    input  wire logic       pin_share_select_i,
    input  wire logic       input_function_select_i,
    input  wire logic       clock_master_select_i,
    input  wire logic [2:0] clock_select_i,
    input  wire logic       prescaler_enable_i,
    input  wire logic       ack_enable_i,
    input  wire logic       direction_select_i,
    input  wire logic       start_gen_enable_i,
    input  wire logic [2:0] bit_count_i,
    input  wire logic       msb_first_i,
    // Clock source pulses from the same clock domain
    input  wire logic       sub_clk_tick_i,
    input  wire logic       timer3_tick_i,
    // Shift buffer writes (FIFO fill side)
    input  wire logic       wr_valid_i,
    input  wire logic [7:0] wr_data_i,
    output logic            wr_ready_o,
    // Ack level bit access
    input  wire logic       ack_level_wr_i,
    input  wire logic       ack_level_wdata_i,
    output logic            ack_level_o,
    // Status and control
    input  wire logic       busy_clear_i,
    input  wire logic       start_flag_clear_i,
    output logic            bus_busy_o,
    output logic            start_detected_o,
    output logic            transfer_done_irq_o,
    output logic [7:0]      rx_data_o,
    // Bus pins, open drain
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_o,
    input  wire logic       scl_i,
    output logic            scl_o,
    output logic            scl_oe_o,
    input  wire logic       serial_in_pin_i
);
    initial begin
        if (FIFO_DEPTH < 2) $error("sme_engine: FIFO_DEPTH too small");
    end

    // Pin synchronisers; stage one feeds stage two only
    logic [1:0] sda_sync_reg, scl_sync_reg, sin_sync_reg;
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sda_sync_reg <= 2'h3;
            scl_sync_reg <= 2'h3;
            sin_sync_reg <= 2'h3;
        end else begin
            sda_sync_reg <= {sda_sync_reg[0], sda_i};
            scl_sync_reg <= {scl_sync_reg[0], scl_i};
            sin_sync_reg <= {sin_sync_reg[0], serial_in_pin_i};
        end
    end
    logic sda_s, scl_s, data_in;
    assign sda_s   = sda_sync_reg[1];
    assign scl_s   = scl_sync_reg[1];
    assign data_in = pin_share_select_i ? sda_s : sin_sync_reg[1];

    // Write data FIFO between software and the shift buffer
    logic       fifo_valid, fifo_pop;
    logic [7:0] fifo_data;
    sme_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
        .core_clk_i  (core_clk_i),
        .reset_n_i   (reset_n_i),
        .in_valid_i  (wr_valid_i),
        .in_data_i   (wr_data_i),
        .in_ready_o  (wr_ready_o),
        .out_valid_o (fifo_valid),
        .out_data_o  (fifo_data),
        .out_ready_i (fifo_pop)
    );

    // Clock source group
    logic [`SME_PSC_W-1:0] psc_reg, psc_next;   // Dedicated prescaler
    logic [1:0]            sub_reg, sub_next;   // Subclock divider
    logic [1:0]            ph_reg, ph_next;     // Divide-by-three phase
    logic                  src_tick;            // Selected source pulse
    logic                  fall_tick;           // Bus clock falling edge

    // Source select and divide by three
    always_comb begin
        psc_next = prescaler_enable_i ? psc_reg + 1'b1 : '0;
        sub_next = sub_clk_tick_i ? sub_reg + 1'b1 : sub_reg;
        unique case (clock_select_i)
            `SME_SRC_FOSC2:  src_tick = prescaler_enable_i && (psc_reg & `SME_PSC_M2) == `SME_PSC_M2;
            `SME_SRC_FOSC4:  src_tick = prescaler_enable_i && (psc_reg & `SME_PSC_M4) == `SME_PSC_M4;
            `SME_SRC_FOSC16: src_tick = prescaler_enable_i && (psc_reg & `SME_PSC_M16) == `SME_PSC_M16;
            `SME_SRC_FOSC32: src_tick = prescaler_enable_i && psc_reg == `SME_PSC_M32;
            `SME_SRC_FS2:    src_tick = sub_clk_tick_i && (sub_reg & `SME_SUB_M2) == `SME_SUB_M2;
            `SME_SRC_FS4:    src_tick = sub_clk_tick_i && sub_reg == `SME_SUB_M4;
            `SME_SRC_TMR3:   src_tick = timer3_tick_i;
            default:         src_tick = 1'b0;   // Unused code stops the bus clock
        endcase
        // Clock slave is not supported; no master select, no clock
        src_tick = src_tick && clock_master_select_i;
        // three source pulses per bus clock
        ph_next = ph_reg;
        if (src_tick) begin
            ph_next = (ph_reg == `SME_PH_HI2) ? `SME_PH_LOW : ph_reg + 1'b1;
        end
        fall_tick = src_tick && ph_reg == `SME_PH_HI2;
    end

    // Clock source registers
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            psc_reg <= '0;
            sub_reg <= '0;
            ph_reg  <= `SME_PH_LOW;
        end else begin
            psc_reg <= psc_next;
            sub_reg <= sub_next;
            ph_reg  <= ph_next;
        end
    end

    // Engine group
    sme_state_e st_reg, st_next;
    logic [7:0] shift_reg, shift_next;      // Transmit/receive shift buffer
    logic [3:0] bits_reg, bits_next;        // Bits left in this byte
    logic       dir_reg, dir_next;          // Latched direction, 1 = receive
    logic       busy_reg, busy_next;
    logic       stflag_reg, stflag_next;
    logic       ack_reg, ack_next;
    logic       irq_reg, irq_next;
    logic [7:0] rx_reg, rx_next;
    logic       sda_rel_reg, sda_rel_next;  // Released (high) when set
    logic       scl_rel_reg, scl_rel_next;
    logic       sda_prev_reg;               // Previous synced data level
    logic       foreign_start;

    // Falling data with clock high, seen on the synced pins
    assign foreign_start = sda_prev_reg && !sda_s && scl_s && input_function_select_i;

    // Engine sequence
    always_comb begin
        st_next      = st_reg;
        shift_next   = shift_reg;
        bits_next    = bits_reg;
        dir_next     = dir_reg;
        busy_next    = busy_reg;
        stflag_next  = stflag_reg && !start_flag_clear_i;
        ack_next     = ack_level_wr_i ? ack_level_wdata_i : ack_reg;
        irq_next     = 1'b0;
        rx_next      = rx_reg;
        sda_rel_next = sda_rel_reg;
        scl_rel_next = scl_rel_reg;
        fifo_pop     = 1'b0;
        if (busy_clear_i) begin
            busy_next = 1'b0;
        end
        unique case (st_reg)
            SME_IDLE, SME_HOLD: begin
                // write starts transfer; in HOLD only early in the low phase, so
                // a byte never starts half way through a bus clock period.
                // Limitation: a source ticking every cycle leaves no such gap
                if (fifo_valid && (st_reg == SME_IDLE
                    || (busy_reg && !busy_clear_i && ph_reg == `SME_PH_LOW && !src_tick))) begin
                    fifo_pop   = 1'b1;
                    busy_next  = 1'b1;
                    // address byte or free data alike
                    shift_next = fifo_data;
                    bits_next  = (bit_count_i == 3'h0) ? `SME_BIT_FULL : {1'b0, bit_count_i};
                    dir_next   = direction_select_i;
                    // first byte always gets a start
                    st_next    = (st_reg == SME_IDLE || start_gen_enable_i) ? SME_START_A : SME_BITS;
                end else if (st_reg == SME_HOLD && !busy_reg && src_tick) begin
                    sda_rel_next = 1'b0;
                    st_next      = SME_STOP_A;
                end
            end
            SME_START_A: begin
                // Both lines released until the next bus clock fall, then the start
                sda_rel_next = 1'b1;
                scl_rel_next = 1'b1;
                if (fall_tick) begin
                    st_next = SME_START_B;
                end
            end
            SME_START_B: begin
                sda_rel_next = 1'b0;
                if (fall_tick) begin
                    scl_rel_next = 1'b0;
                    st_next      = SME_BITS;
                end
            end
            SME_BITS: begin
                // Data moves a tick after the fall and the clock rises a tick later,
                // so data never changes with the clock high and mimics a start
                if (src_tick && ph_reg == `SME_PH_LOW) begin
                    sda_rel_next = dir_reg ? 1'b1
                                 : (msb_first_i ? shift_reg[7] : shift_reg[0]);
                end
                if (src_tick && ph_reg == `SME_PH_HI1) begin
                    scl_rel_next = 1'b1;
                end
                if (fall_tick) begin
                    scl_rel_next = 1'b0;
                    shift_next   = msb_first_i ? {shift_reg[6:0], data_in}
                                               : {data_in, shift_reg[7:1]};
                    bits_next    = bits_reg - 1'b1;
                    if (dir_reg) begin
                        rx_next = msb_first_i ? {shift_reg[6:0], data_in}
                                              : {data_in, shift_reg[7:1]};
                    end
                    if (bits_reg == `SME_BIT_ONE) begin
                        st_next  = ack_enable_i ? SME_ACK : SME_HOLD;
                        irq_next = !ack_enable_i;
                    end
                end
            end
            SME_ACK: begin
                if (src_tick && ph_reg == `SME_PH_LOW) begin
                    // released for slave ack; drive own level
                    sda_rel_next = dir_reg ? ack_reg : 1'b1;
                end
                // Clock released one tick after the data settled
                if (src_tick && ph_reg == `SME_PH_HI1) begin
                    scl_rel_next = 1'b1;
                end
                if (fall_tick) begin
                    scl_rel_next = 1'b0;
                    if (!dir_reg) begin
                        ack_next = data_in;
                    end
                    irq_next = 1'b1;
                    st_next  = SME_HOLD;
                end
            end
            SME_STOP_A: begin
                // Data held low, then the clock goes high
                if (src_tick) begin
                    scl_rel_next = 1'b1;
                    st_next      = SME_STOP_B;
                end
            end
            SME_STOP_B: begin
                if (src_tick) begin
                    sda_rel_next = 1'b1;
                    st_next      = SME_IDLE;
                end
            end
            default: st_next = SME_IDLE;
        endcase
        if (foreign_start && busy_reg && start_gen_enable_i
            && (st_reg == SME_BITS || st_reg == SME_ACK)) begin
            stflag_next  = 1'b1;
            irq_next     = 1'b1;
            busy_next    = 1'b0;
            sda_rel_next = 1'b1;
            scl_rel_next = 1'b1;
            st_next      = SME_IDLE;
        end
    end

    // Engine registers
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_reg       <= SME_IDLE;
            shift_reg    <= 8'h00;
            bits_reg     <= 4'h0;
            dir_reg      <= 1'b0;
            busy_reg     <= 1'b0;
            stflag_reg   <= 1'b0;
            ack_reg      <= 1'b0;
            irq_reg      <= 1'b0;
            rx_reg       <= 8'h00;
            sda_rel_reg  <= 1'b1;
            scl_rel_reg  <= 1'b1;
            sda_prev_reg <= 1'b1;
        end else begin
            st_reg       <= st_next;
            shift_reg    <= shift_next;
            bits_reg     <= bits_next;
            dir_reg      <= dir_next;
            busy_reg     <= busy_next;
            stflag_reg   <= stflag_next;
            ack_reg      <= ack_next;
            irq_reg      <= irq_next;
            rx_reg       <= rx_next;
            sda_rel_reg  <= sda_rel_next;
            scl_rel_reg  <= scl_rel_next;
            sda_prev_reg <= sda_s;
        end
    end

    // Open drain: pull low only, enable while driving
    assign sda_o               = 1'b0;
    assign scl_o               = 1'b0;
    assign sda_oe_o            = !sda_rel_reg;
    assign scl_oe_o            = !scl_rel_reg;
    assign bus_busy_o          = busy_reg;
    assign start_detected_o    = stflag_reg;
    assign ack_level_o         = ack_reg;
    assign transfer_done_irq_o = irq_reg;
    assign rx_data_o           = rx_reg;

    AST_BUSY_ON_WRITE: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        fifo_pop && !busy_clear_i |=> bus_busy_o)
        else $error("busy not set after write");
    AST_START_SHAPE: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        st_reg == SME_START_B && $past(st_reg) == SME_START_A |-> !scl_oe_o && $past(!sda_oe_o))
        else $error("start formed with clock low");
    AST_STOP_SHAPE: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        st_reg == SME_STOP_B && st_next == SME_IDLE |=> !sda_oe_o && !scl_oe_o)
        else $error("stop not finished with both lines high");
    AST_ACK_RELEASE: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        st_reg == SME_ACK && !dir_reg && scl_rel_reg |-> !sda_oe_o)
        else $error("data driven in received ack slot");
    AST_ACK_FROZEN: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        st_reg == SME_ACK ##1 st_reg == SME_ACK |-> $stable(shift_reg))
        else $error("shift buffer moved during ack");
    AST_RX_ACK_LEVEL: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        st_reg == SME_ACK && dir_reg && scl_rel_reg |-> sda_oe_o == !ack_reg)
        else $error("wrong ack level in receive");
    AST_RX_RELEASE: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        st_reg == SME_BITS && dir_reg && scl_rel_reg |-> !sda_oe_o)
        else $error("data driven while receiving");
    AST_ACK_STORE: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        st_reg == SME_ACK && !dir_reg && fall_tick && !foreign_start
        |=> ack_level_o == $past(data_in) && transfer_done_irq_o)
        else $error("slave ack not stored");
    AST_FOREIGN_START: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        foreign_start && busy_reg && start_gen_enable_i && st_reg == SME_BITS
        |=> start_detected_o && !bus_busy_o && transfer_done_irq_o ##1 !transfer_done_irq_o)
        else $error("foreign start not handled");
    AST_DIV3: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        src_tick && ph_reg == `SME_PH_HI2 |=> ph_reg == `SME_PH_LOW)
        else $error("bus clock phase wrap wrong");
    AST_PSC_OFF: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        !prescaler_enable_i |=> psc_reg == '0)
        else $error("prescaler ran while disabled");
endmodule // sme_engine

// ---- sme_engine_tb_top.sv ----
// Bench for the two-wire serial engine; each scenario drives and judges itself.
// Assumes the slave model on the bus and pull-ups on both lines.
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin bad_count++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module sme_engine_tb_top;
    logic       core_clk = 0, reset_n = 0, psc_en = 1, ack_en = 1, dir = 0, ste = 1, msb = 1;
    logic       lvl_wr = 0, lvl_d = 0, busy_clr = 0, flag_clr = 0, wr_valid = 0;
    logic       sub_tick = 0, tmr_tick = 0, rd_sl = 0, ack_sl = 1, tb_pull = 0;
    logic [2:0] csel = 0, bcnt = 0;
    logic [7:0] wr_data = 0, sl_data = 0, sh = 0, rx;
    logic       wr_ready, ack_level, busy, start_det, irq, sda_oe, scl_oe, sl_pull;
    logic       ack_bit, ack_oe, bits_oe;
    int         bad_count = 0, check_count = 0, cyc = 0, bitn = 0, starts = 0, stops = 0;
    int         sdiv = 0, tdiv = 0, n, s0;
    realtime    t0;
    // Open-drain lines: released means pulled high
    wire sda_w = ~(sda_oe | sl_pull | tb_pull);
    wire scl_w = ~scl_oe;
    initial forever #2 core_clk = ~core_clk;
    // Subclock every 5 cycles, timer output every 7; rates scaled for short runs
    always @(negedge core_clk) begin
        sdiv = (sdiv + 1) % 5;
        tdiv = (tdiv + 1) % 7;
        sub_tick = (sdiv == 0);
        tmr_tick = (tdiv == 0);
    end
    // Bus monitor: conditions, bit values, who drives the data line
    always @(negedge sda_w) if (scl_w) begin
        starts++;
        bitn = 0;
    end
    always @(posedge sda_w) if (scl_w) stops++;
    always @(posedge scl_w) begin
        if (bitn < 8) begin
            sh = {sh[6:0], sda_w};
            bits_oe = bits_oe | sda_oe;
        end else begin
            ack_bit = sda_w;
            ack_oe = sda_oe;
        end
        bitn = (bitn == 8) ? 0 : bitn + 1;
    end
    // Hang guard well above the longest run
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 40000) begin
            bad_count++;
            report_and_stop;
        end
    end
    // pin share, start detect input and clock master set as required
    sme_engine #(.FIFO_DEPTH(8)) dut_u (
        .core_clk_i(core_clk), .reset_n_i(reset_n), .pin_share_select_i(1'b1),
        .input_function_select_i(1'b1), .clock_master_select_i(1'b1), .clock_select_i(csel),
        .prescaler_enable_i(psc_en), .ack_enable_i(ack_en), .direction_select_i(dir),
        .start_gen_enable_i(ste), .bit_count_i(bcnt), .msb_first_i(msb),
        .sub_clk_tick_i(sub_tick), .timer3_tick_i(tmr_tick), .wr_valid_i(wr_valid),
        .wr_data_i(wr_data), .wr_ready_o(wr_ready), .ack_level_wr_i(lvl_wr),
        .ack_level_wdata_i(lvl_d), .ack_level_o(ack_level), .busy_clear_i(busy_clr),
        .start_flag_clear_i(flag_clr), .bus_busy_o(busy), .start_detected_o(start_det),
        .transfer_done_irq_o(irq), .rx_data_o(rx), .sda_i(sda_w), .sda_o(), .sda_oe_o(sda_oe),
        .scl_i(scl_w), .scl_o(), .scl_oe_o(scl_oe), .serial_in_pin_i(1'b1));
    sme_slave_model slave_u (.scl_i(scl_w), .sda_i(sda_w), .rst_n_i(reset_n), .rd_i(rd_sl),
        .ack_low_i(ack_sl), .data_i(sl_data), .sda_pull_o(sl_pull));
    task report_and_stop;
        $display("checks=%0d mismatches=%0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task do_reset;
        reset_n = 0;
        repeat (4) @(negedge core_clk);
        reset_n = 1;
    endtask
    task put(input logic [7:0] d);
        @(negedge core_clk);
        wr_valid = 1;
        wr_data = d;
        bits_oe = 0;
        @(negedge core_clk);
        wr_valid = 0;
    endtask
    // Bounded wait for the one-cycle done pulse
    task wait_irq;
        for (int k = 0; k < 4000 && irq !== 1'b1; k++) @(negedge core_clk);
        @(negedge core_clk);
    endtask
    task t_write(input logic [7:0] d, input logic ackl);
        dir = 0;
        rd_sl = 0;
        ack_sl = ackl;
        put(d);
        repeat (2) @(negedge core_clk);
        `CHK(busy, 1'b1)
        wait_irq;
        `CHK(sh, d)
        `CHK(ack_level, ~ackl)
        `CHK(ack_oe, 1'b0)
    endtask
    task t_read(input logic [7:0] d, input logic lvl);
        dir = 1; // receive after the address byte
        rd_sl = 1;
        sl_data = d;
        lvl_d = lvl;
        lvl_wr = 1;
        @(negedge core_clk);
        lvl_wr = 0;
        put(8'hff);
        wait_irq;
        `CHK(rx, d)
        `CHK(bits_oe, 1'b0)
        `CHK(ack_bit, lvl)
    endtask
    task t_stop;
        s0 = stops;
        busy_clr = 1;
        @(negedge core_clk);
        busy_clr = 0;
        for (int k = 0; k < 300 && stops == s0; k++) @(negedge core_clk);
        `CHK(busy, 1'b0)
        `CHK(stops - s0, 1)
    endtask
    // Rate per source code: three source periods per bus bit
    task t_rate;
        int per[7] = '{2, 4, 16, 32, 10, 20, 7};
        for (int c = 0; c < 7; c++) begin
            csel = c[2:0];
            do_reset;
            put(8'hff);
            @(posedge scl_w);
            t0 = $realtime;
            @(posedge scl_w);
            `CHK(int'(($realtime - t0) / 4), 3 * per[c])
        end
        csel = 0;
        psc_en = 0;
        do_reset;
        put(8'hff);
        repeat (300) @(negedge core_clk);
        `CHK({scl_oe, sda_oe}, 2'h0)
        psc_en = 1;
    endtask
    initial begin
        do_reset;
        `CHK({busy, sda_oe, scl_oe, wr_ready}, 4'h1)
        s0 = starts;
        t_write(8'ha4, 1);
        `CHK(starts - s0, 1)
        ste = 0;
        t_write(8'h5b, 1);
        t_read(8'h3c, 0);
        t_read(8'hc3, 1);
        `CHK(starts - s0, 1)
        t_stop;
        ste = 1;
        t_write(8'h12, 0);
        t_stop;
        // Short byte with no ack slot: four bits, done at the last fall
        ack_en = 0;
        bcnt = 3'h4;
        put(8'h9c);
        wait_irq;
        `CHK(sh[3:0], 4'h9)
        `CHK(busy, 1'b1)
        bcnt = 3'h0;
        ack_en = 1;
        t_stop;
        // Foreign start during the first bit of a slow byte
        csel = 3;
        put(8'hff);
        @(posedge scl_w);
        repeat (20) @(negedge core_clk);
        tb_pull = 1;
        wait_irq;
        `CHK({start_det, busy}, 2'h2)
        tb_pull = 0;
        flag_clr = 1;
        @(negedge core_clk);
        flag_clr = 0;
        @(negedge core_clk);
        `CHK(start_det, 1'b0)
        t_rate;
        // Fill the buffer until refused, then drain it as one exchange
        ste = 0;
        ack_sl = 1;
        rd_sl = 0;
        dir = 0;
        do_reset;
        s0 = starts;
        n = 0;
        @(negedge core_clk);
        while (wr_ready === 1'b1 && n < 20) begin
            wr_valid = 1;
            wr_data = n[7:0];
            n++;
            @(negedge core_clk);
        end
        wr_valid = 0;
        `CHK(n, 9)
        repeat (9) wait_irq;
        `CHK(wr_ready, 1'b1)
        `CHK(starts - s0, 1)
        t_stop;
        report_and_stop;
    end
endmodule // sme_engine_tb_top

// ---- sme_pkg.sv ----
// Types for the single-master two-wire serial engine.
// Assumes sme_cfg.svh supplies the numeric constants.
package sme_pkg;
    // Engine sequence states
    typedef enum logic [2:0] {
        SME_IDLE,
        SME_START_A,
        SME_START_B,
        SME_BITS,
        SME_ACK,
        SME_HOLD,
        SME_STOP_A,
        SME_STOP_B
    } sme_state_e;
endpackage

// ---- sme_slave_model.sv ----
// Behavioural two-wire slave: acks written bytes, returns a byte on reads.
// Assumes the bench resolves both lines with pull-ups.
`timescale 1ns/1ps
module sme_slave_model (
    // Bus levels and bench reset
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    input  wire logic       rst_n_i,
    // Behaviour controls
    input  wire logic       rd_i,
    input  wire logic       ack_low_i,
    input  wire logic [7:0] data_i,
    // Pull-down request on the data line
    output logic            sda_pull_o
);
    int   cnt   = 0;    // Clock falls since start, -1 until the start's own fall
    logic quiet = 1'b1; // Silent until a start is seen
    // Pull is combinational so a mode change in the low phase shows at once;
    // otherwise it moves only on a clock fall, never while the clock is high
    assign sda_pull_o = ~quiet & (cnt >= 0)
                        & ((cnt < 8) ? rd_i & ~data_i[7-cnt] : ~rd_i & ack_low_i);
    always @(negedge rst_n_i) quiet = 1'b1;
    // A start resynchronises the bit count
    always @(negedge sda_i) if (scl_i) begin
        cnt = -1;
        quiet = 1'b0;
    end
    // A master refusal after a read byte ends our driving
    always @(posedge scl_i) if (cnt == 8 && rd_i && sda_i) quiet = 1'b1;
    // Count 8 is the ack slot; its fall starts the next byte
    always @(negedge scl_i) cnt = (cnt == 8) ? 0 : cnt + 1;
endmodule // sme_slave_model
